/* File: design/cmcp_regs.svh */
// Register offsets, addresses, reset values and timing figures of the chassis manager
`ifndef CMCP_REGS_SVH
`define CMCP_REGS_SVH

// Management bus addresses, 8-bit form with the R/W bit as bit 0
`define CMCP_ADDR_DEFAULT 8'h5c
`define CMCP_ADDR_ALT_A 8'h58
`define CMCP_ADDR_ALT_B 8'h5a

// Register offsets (command codes)
`define CMCP_REG_AUX5V_HIGH 8'h00
`define CMCP_REG_AUX5V_LOW 8'h01
`define CMCP_REG_3P3_HIGH 8'h02
`define CMCP_REG_3P3_LOW 8'h03
`define CMCP_REG_5V_HIGH 8'h04
`define CMCP_REG_5V_LOW 8'h05
`define CMCP_REG_POS12_HIGH 8'h06
`define CMCP_REG_POS12_LOW 8'h07
`define CMCP_REG_NEG12_HIGH 8'h08
`define CMCP_REG_NEG12_LOW 8'h09
`define CMCP_REG_SOURCE_SEL 8'h0e
`define CMCP_REG_SLOT_REQ 8'h0f
`define CMCP_REG_EXT_REQ 8'h10
`define CMCP_REG_SUPPLY_A 8'h11
`define CMCP_REG_SUPPLY_B 8'h12
`define CMCP_REG_SUPPLY_C 8'h13
`define CMCP_REG_SUPPLY_D 8'h14
`define CMCP_REG_SYNC_DIV 8'h45

// Reset and readback values
`define CMCP_SYNC_DIV_RST 8'h01
`define CMCP_BYTE_HIGH 8'h01
`define CMCP_BYTE_LOW 8'h00
`define CMCP_UNMAPPED_BYTE 8'h00

// Timing, in ns
`define CMCP_CLK_NS 40
`define CMCP_REF_LOSS_NS 1000
`define CMCP_SETTLE_NS 2000

`endif

/* File: design/cmcp_pkg.sv */
// Types shared by the chassis manager logic
package cmcp_pkg;

  typedef enum logic [1:0] {
    CMCP_REF_INT = 2'b00,
    CMCP_REF_SLOT = 2'b01,
    CMCP_REF_REAR = 2'b10
  } cmcp_ref_e;

  typedef enum logic [3:0] {
    CMCP_S_IDLE = 4'b0000,
    CMCP_S_ADDR = 4'b0001,
    CMCP_S_AACK = 4'b0010,
    CMCP_S_CMD = 4'b0011,
    CMCP_S_CACK = 4'b0100,
    CMCP_S_WDAT = 4'b0101,
    CMCP_S_WACK = 4'b0110,
    CMCP_S_RDAT = 4'b0111,
    CMCP_S_RACK = 4'b1000
  } cmcp_smb_e;

  typedef struct packed {
    logic [15:0] aux5v;
    logic [15:0] rail_3p3;
    logic [15:0] rail_5v;
    logic [15:0] rail_pos12;
    logic [15:0] rail_neg12;
  } cmcp_rails_s;

  typedef struct packed {
    logic power_source_selector;
    logic slot_power_request_in;
    logic external_power_request_in;
  } cmcp_power_in_s;

endpackage

/* File: design/cmcp_top.sv */
// Chassis manager: reference selection, sync divider and management bus target
//
// What this block does
// R1: Timing-slot 10 MHz reference present: lock all clocks and rear output to it.
// R2: No slot reference but rear input clocked: lock everything to rear input.
// R3: Neither reference present: generate all clocks from the internal oscillator.
// R4: Source chosen automatically: slot, then rear input, then internal.
// R5: Source changes switch outputs without glitches; derived clocks follow.
// R6: Divider 2..255: sync at 10 MHz over n, control pin restarts it.
// R7: Divider 0: sync at 10 MHz, control pin enables it.
// R8: Divider 1: sync at 10 MHz, control pin ignored.
// R9: Management unit is an I2C/SMBus target on the backplane bus.
// R10: Target address 5Ch by default, otherwise only 58h or 5Ah.
// R11: Sensor readings come over a secondary side decoupled from host bus.
// R12: Aux 5 V millivolts read-only, high byte 0x00, low 0x01.
// R13: 3.3 V millivolts read-only, high byte 0x02, low 0x03.
// R14: 5 V millivolts read-only, high byte 0x04, low 0x05.
// R15: +12 V millivolts read-only, high byte 0x06, low 0x07.
// R16: -12 V millivolts read-only, high byte 0x08, low 0x09.
// R17: Byte 0x0E shows power source selector: zero external, nonzero slot.
// R18: Byte 0x0F shows slot power request level, zero low, nonzero high.
// R19: Byte 0x10 shows external power request level, zero low, nonzero high.
// R20: Bytes 0x11..0x14 show the four supply enable outputs.
// R21: Byte-data transfers, command equals address; writes to read-only ignored.
`timescale 1ns/10ps
`default_nettype none
`include "cmcp_regs.svh"

module cmcp_top import cmcp_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_smb_clk,
  input wire logic i_smb_dat,
  output logic o_smb_dat,
  output logic o_smb_dat_oe,
  input wire logic [1:0] i_addr_strap,
  input wire logic i_slot_ref_clk,
  input wire logic i_rear_reference_input,
  input wire logic i_clk10,
  input wire logic i_sync_ctrl,
  input wire cmcp_power_in_s i_power,
  input wire cmcp_rails_s i_rails,
  output cmcp_ref_e o_ref_select,
  output logic o_ref_switch,
  output logic o_sync100,
  output logic [3:0] o_supply_enable
);

  localparam int REF_LOSS_C = `CMCP_REF_LOSS_NS / `CMCP_CLK_NS;
  localparam int SETTLE_C = (`CMCP_SETTLE_NS + `CMCP_CLK_NS - 1) / `CMCP_CLK_NS;
  localparam int NPIN = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;

  assign pin_raw = {i_addr_strap, i_power, i_sync_ctrl, i_clk10, i_rear_reference_input,
                    i_slot_ref_clk, i_smb_dat, i_smb_clk};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      // Bus lines idle high, so no false edge after reset
      localparam logic IDLE_LVL = (gi < 2);
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          pin_s1[gi] <= IDLE_LVL;
          pin_s2[gi] <= IDLE_LVL;
          pin_s3[gi] <= IDLE_LVL;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
        end
      end
    end
  endgenerate

  logic scl_s;
  logic sda_s;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic smb_start;
  logic smb_stop;
  logic ctrl_s;
  logic ctrl_rise;
  logic tick10;
  logic [1:0] strap_s;
  cmcp_power_in_s pwr_s;

  assign scl_s = pin_s2[0];
  assign sda_s = pin_s2[1];
  assign sda_p = pin_s3[1];
  assign scl_rise = pin_s2[0] & ~pin_s3[0];
  assign scl_fall = ~pin_s2[0] & pin_s3[0];
  assign smb_start = scl_s & pin_s3[0] & sda_p & ~sda_s;
  assign smb_stop = scl_s & pin_s3[0] & ~sda_p & sda_s;
  assign tick10 = pin_s2[4] & ~pin_s3[4];
  assign ctrl_s = pin_s2[5];
  assign ctrl_rise = pin_s2[5] & ~pin_s3[5];
  assign pwr_s = pin_s2[8:6];
  assign strap_s = pin_s2[10:9];

  ////////////////////////////////////////////////////////////////////////////
  // Reference presence detection and source selection
  logic [1:0] ref_present;
  logic [7:0] loss_cnt [2];
  logic [7:0] next_loss_cnt [2];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_ref
      always_comb begin
        if (pin_s2[2+gi] ^ pin_s3[2+gi]) begin
          next_loss_cnt[gi] = 8'h00;
        end else if (loss_cnt[gi] != 8'(REF_LOSS_C)) begin
          next_loss_cnt[gi] = loss_cnt[gi] + 8'h01;
        end else begin
          next_loss_cnt[gi] = loss_cnt[gi];
        end
      end
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          loss_cnt[gi] <= 8'(REF_LOSS_C);
        end else begin
          loss_cnt[gi] <= next_loss_cnt[gi];
        end
      end
      assign ref_present[gi] = (loss_cnt[gi] != 8'(REF_LOSS_C));
    end
  endgenerate

  cmcp_ref_e cand;
  cmcp_ref_e ref_sel;
  cmcp_ref_e next_ref_sel;
  logic [7:0] settle_cnt;
  logic [7:0] next_settle_cnt;
  logic switch_now;
  logic next_ref_switch;

  always_comb begin
    if (ref_present[0]) begin
      cand = CMCP_REF_SLOT; // [R1] [R4]
    end else if (ref_present[1]) begin
      cand = CMCP_REF_REAR; // [R2]
    end else begin
      cand = CMCP_REF_INT; // [R3]
    end
  end

  // New source taken only after it has held for the settle time
  assign switch_now = (cand != ref_sel) && (settle_cnt == 8'(SETTLE_C - 1)); // [R5]

  always_comb begin
    next_ref_sel = ref_sel;
    next_settle_cnt = 8'h00;
    next_ref_switch = 1'b0;
    if (switch_now) begin
      next_ref_sel = cand; // [R4]
      next_ref_switch = 1'b1;
    end else if (cand != ref_sel) begin
      next_settle_cnt = settle_cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ref_sel <= CMCP_REF_INT;
      settle_cnt <= 8'h00;
      o_ref_switch <= 1'b0;
    end else begin
      ref_sel <= next_ref_sel;
      settle_cnt <= next_settle_cnt;
      o_ref_switch <= next_ref_switch;
    end
  end

  assign o_ref_select = ref_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Sync divider
  logic [7:0] sync_div;
  logic [7:0] sync_cnt;
  logic [7:0] next_sync_cnt;
  logic next_sync100;

  always_comb begin
    next_sync_cnt = sync_cnt;
    next_sync100 = 1'b0;
    if (sync_div == 8'h00) begin
      next_sync100 = tick10 & ctrl_s; // [R7]
      next_sync_cnt = 8'h00;
    end else if (sync_div == 8'h01) begin
      next_sync100 = tick10; // [R8]
      next_sync_cnt = 8'h00;
    end else if (ctrl_rise || o_ref_switch) begin
      next_sync_cnt = 8'h00; // [R6] [R5]
    end else if (tick10) begin
      next_sync100 = (sync_cnt == 8'h00); // [R6]
      next_sync_cnt = (sync_cnt >= sync_div - 8'h01) ? 8'h00 : sync_cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_cnt <= 8'h00;
      o_sync100 <= 1'b0;
    end else begin
      sync_cnt <= next_sync_cnt;
      o_sync100 <= next_sync100;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power request routing and strap capture
  logic [7:0] own_addr;
  logic [7:0] next_own_addr;
  logic strap_done;
  logic [1:0] strap_wait;
  logic [1:0] next_strap_wait;

  // Strap taken at the third edge, once through the synchroniser
  assign strap_done = (strap_wait == 2'h3);
  logic [3:0] next_supply;
  cmcp_rails_s rails;
  cmcp_rails_s next_rails;
  cmcp_smb_e state;

  always_comb begin
    next_supply = {4{pwr_s.power_source_selector ? pwr_s.slot_power_request_in
                                                  : pwr_s.external_power_request_in}};
    next_strap_wait = strap_done ? strap_wait : strap_wait + 2'h1;
    next_own_addr = own_addr;
    if (!strap_done) begin
      unique case (strap_s) // [R10]
        2'b01: next_own_addr = `CMCP_ADDR_ALT_A;
        2'b10: next_own_addr = `CMCP_ADDR_ALT_B;
        default: next_own_addr = `CMCP_ADDR_DEFAULT;
      endcase
    end
    // Sensor copy refreshed only between host transfers
    next_rails = (state == CMCP_S_IDLE) ? i_rails : rails; // [R11]
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_supply_enable <= 4'h0;
      own_addr <= `CMCP_ADDR_DEFAULT;
      strap_wait <= 2'h0;
      rails <= '0;
    end else begin
      o_supply_enable <= next_supply;
      own_addr <= next_own_addr;
      strap_wait <= next_strap_wait;
      rails <= next_rails;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register readback
  function automatic logic [7:0] flag_byte(input logic lvl);
    flag_byte = lvl ? `CMCP_BYTE_HIGH : `CMCP_BYTE_LOW;
  endfunction

  logic [7:0] ptr;
  logic [7:0] rd_byte;

  always_comb begin
    unique case (ptr)
      `CMCP_REG_AUX5V_HIGH: rd_byte = rails.aux5v[15:8]; // [R12]
      `CMCP_REG_AUX5V_LOW: rd_byte = rails.aux5v[7:0]; // [R12]
      `CMCP_REG_3P3_HIGH: rd_byte = rails.rail_3p3[15:8]; // [R13]
      `CMCP_REG_3P3_LOW: rd_byte = rails.rail_3p3[7:0]; // [R13]
      `CMCP_REG_5V_HIGH: rd_byte = rails.rail_5v[15:8]; // [R14]
      `CMCP_REG_5V_LOW: rd_byte = rails.rail_5v[7:0]; // [R14]
      `CMCP_REG_POS12_HIGH: rd_byte = rails.rail_pos12[15:8]; // [R15]
      `CMCP_REG_POS12_LOW: rd_byte = rails.rail_pos12[7:0]; // [R15]
      `CMCP_REG_NEG12_HIGH: rd_byte = rails.rail_neg12[15:8]; // [R16]
      `CMCP_REG_NEG12_LOW: rd_byte = rails.rail_neg12[7:0]; // [R16]
      `CMCP_REG_SOURCE_SEL: rd_byte = flag_byte(pwr_s.power_source_selector); // [R17]
      `CMCP_REG_SLOT_REQ: rd_byte = flag_byte(pwr_s.slot_power_request_in); // [R18]
      `CMCP_REG_EXT_REQ: rd_byte = flag_byte(pwr_s.external_power_request_in); // [R19]
      `CMCP_REG_SUPPLY_A: rd_byte = flag_byte(o_supply_enable[0]); // [R20]
      `CMCP_REG_SUPPLY_B: rd_byte = flag_byte(o_supply_enable[1]); // [R20]
      `CMCP_REG_SUPPLY_C: rd_byte = flag_byte(o_supply_enable[2]); // [R20]
      `CMCP_REG_SUPPLY_D: rd_byte = flag_byte(o_supply_enable[3]); // [R20]
      `CMCP_REG_SYNC_DIV: rd_byte = sync_div;
      default: rd_byte = `CMCP_UNMAPPED_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management bus target
  cmcp_smb_e next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] next_ptr;
  logic rw;
  logic next_rw;
  logic oe;
  logic next_oe;
  logic ack;
  logic next_ack;
  logic [7:0] next_sync_div;

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rw = rw;
    next_oe = oe;
    next_ack = ack;
    next_sync_div = sync_div;
    if (smb_stop) begin
      next_state = CMCP_S_IDLE;
      next_oe = 1'b0;
    end else if (smb_start) begin
      next_state = CMCP_S_ADDR; // [R9]
      next_bitcnt = 4'h0;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        CMCP_S_IDLE: next_oe = 1'b0;
        CMCP_S_ADDR, CMCP_S_CMD, CMCP_S_WDAT: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            next_bitcnt = 4'h0;
            next_oe = 1'b1;
            if (state == CMCP_S_ADDR) begin
              if (shreg[7:1] == own_addr[7:1]) begin
                next_rw = shreg[0]; // [R10]
                next_state = CMCP_S_AACK;
              end else begin
                next_oe = 1'b0;
                next_state = CMCP_S_IDLE;
              end
            end else if (state == CMCP_S_CMD) begin
              next_ptr = shreg; // [R21]
              next_state = CMCP_S_CACK;
            end else begin
              if (ptr == `CMCP_REG_SYNC_DIV) begin
                next_sync_div = shreg; // [R21]
              end
              next_state = CMCP_S_WACK;
            end
          end
        end
        CMCP_S_AACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_shreg = rd_byte;
              next_oe = ~rd_byte[7];
              next_state = CMCP_S_RDAT;
            end else begin
              next_oe = 1'b0;
              next_state = CMCP_S_CMD;
            end
          end
        end
        CMCP_S_CACK, CMCP_S_WACK: begin
          if (scl_fall) begin
            next_oe = 1'b0;
            next_state = CMCP_S_WDAT;
            if (state == CMCP_S_WACK) begin
              next_ptr = ptr + 8'h01;
            end
          end
        end
        CMCP_S_RDAT: begin
          if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              next_oe = 1'b0;
              next_bitcnt = 4'h0;
              next_state = CMCP_S_RACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = ~shreg[6];
            end
          end
        end
        CMCP_S_RACK: begin
          if (scl_rise) begin
            next_ack = ~sda_s;
            if (!sda_s) begin
              next_ptr = ptr + 8'h01;
            end
          end else if (scl_fall) begin
            if (ack) begin
              next_shreg = rd_byte;
              next_oe = ~rd_byte[7];
              next_state = CMCP_S_RDAT;
            end else begin
              next_state = CMCP_S_IDLE;
            end
          end
        end
        default: begin
          next_oe = 1'b0;
          next_state = CMCP_S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= CMCP_S_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      oe <= 1'b0;
      ack <= 1'b0;
      sync_div <= `CMCP_SYNC_DIV_RST;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rw <= next_rw;
      oe <= next_oe;
      ack <= next_ack;
      sync_div <= next_sync_div;
    end
  end

  // Open-drain: only ever pulls low
  assign o_smb_dat = 1'b0;
  assign o_smb_dat_oe = oe;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_sel_prio;
    @(posedge i_clk) disable iff (!i_nrst) switch_now |=> ref_sel == $past(cand);
  endproperty
  a_sel_prio: assert property (p_sel_prio) else $error("source not taken from priority"); // [R4]

  property p_slot_lock;
    @(posedge i_clk) disable iff (!i_nrst) (switch_now && ref_present[0]) |=> ref_sel == CMCP_REF_SLOT;
  endproperty
  a_slot_lock: assert property (p_slot_lock) else $error("slot reference not chosen"); // [R1]

  property p_rear_lock;
    @(posedge i_clk) disable iff (!i_nrst)
      (switch_now && !ref_present[0] && ref_present[1]) |=> ref_sel == CMCP_REF_REAR;
  endproperty
  a_rear_lock: assert property (p_rear_lock) else $error("rear reference not chosen"); // [R2]

  property p_int_lock;
    @(posedge i_clk) disable iff (!i_nrst) (switch_now && ref_present == 2'b00) |=> ref_sel == CMCP_REF_INT;
  endproperty
  a_int_lock: assert property (p_int_lock) else $error("internal reference not chosen"); // [R3]

  property p_glitch_free;
    @(posedge i_clk) disable iff (!i_nrst)
      $changed(ref_sel) |-> o_ref_switch && $past(settle_cnt) == 8'(SETTLE_C - 1);
  endproperty
  a_glitch_free: assert property (p_glitch_free) else $error("source changed before settling"); // [R5]

  property p_div_n;
    @(posedge i_clk) disable iff (!i_nrst)
      (sync_div >= 8'h02 && ctrl_rise) |=> sync_cnt == 8'h00 && !o_sync100;
  endproperty
  a_div_n: assert property (p_div_n) else $error("sync restart missed"); // [R6]

  property p_div_zero;
    @(posedge i_clk) disable iff (!i_nrst) (sync_div == 8'h00 && !ctrl_s) |=> !o_sync100;
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("sync not gated by enable"); // [R7]

  property p_div_one;
    @(posedge i_clk) disable iff (!i_nrst) (sync_div == 8'h01 && $stable(sync_div)) |=> o_sync100 == $past(tick10);
  endproperty
  a_div_one: assert property (p_div_one) else $error("sync not at full rate"); // [R8]

  property p_addr_match;
    @(posedge i_clk) disable iff (!i_nrst)
      (state == CMCP_S_ADDR && next_state == CMCP_S_AACK) |-> shreg[7:1] == own_addr[7:1] ##1 o_smb_dat_oe;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("acknowledged a foreign address"); // [R10]

  property p_ro_write;
    @(posedge i_clk) disable iff (!i_nrst) $changed(sync_div) |-> $past(ptr) == `CMCP_REG_SYNC_DIV;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write landed off the divider"); // [R21]

  property p_supply_view;
    @(posedge i_clk) disable iff (!i_nrst)
      (ptr == `CMCP_REG_SUPPLY_A) |-> (rd_byte != 8'h00) == o_supply_enable[0];
  endproperty
  a_supply_view: assert property (p_supply_view) else $error("supply byte wrong"); // [R20]

  c_switch: cover property (@(posedge i_clk) disable iff (!i_nrst) o_ref_switch);
  c_read: cover property (@(posedge i_clk) disable iff (!i_nrst) state == CMCP_S_RACK && ack);
  c_write: cover property (@(posedge i_clk) disable iff (!i_nrst) $changed(sync_div));
  c_sync_div: cover property (@(posedge i_clk) disable iff (!i_nrst) o_sync100 && sync_div > 8'h02);

endmodule // cmcp_top

`default_nettype wire

/* File: testbench/cmcp_host_model.sv */
// SMBus host model for the chassis manager's management bus
`timescale 1ns/10ps
`default_nettype none

module cmcp_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rdata
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    o_done = 1'b0;
    o_nack = 1'b0;
    o_rdata = 8'h00;
  end

  // One bit, 320 ns; SCL stands high between frames
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe <= ~b;
    #160 o_scl <= 1'b1;
    #80 r = i_sda;
    #80 o_scl <= 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic nack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(1'b1, nack);
  endtask

  // Byte-data write or read, command code is the offset
  task automatic xfer(input logic [7:0] addr, input logic [7:0] cmd, input logic [7:0] wdat, input logic rd);
    logic [7:0] r;
    logic a;
    logic nack;
    o_sda_oe <= 1'b1;
    #160 o_scl <= 1'b0;
    byte_io(addr, r, nack);
    if (!nack) begin
      byte_io(cmd, r, a);
      nack = a;
      if (rd) begin
        o_sda_oe <= 1'b0;
        #160 o_scl <= 1'b1;
        #160 o_sda_oe <= 1'b1;
        #160 o_scl <= 1'b0;
        byte_io(addr | 8'h01, r, a);
        nack = nack | a;
        byte_io(8'hff, r, a);
      end else begin
        byte_io(wdat, r, a);
        nack = nack | a;
        r = 8'h00;
      end
    end
    o_sda_oe <= 1'b1;
    #160 o_scl <= 1'b1;
    #160 o_sda_oe <= 1'b0;
    #160;
    @(posedge i_clk);
    o_rdata <= nack ? 8'h00 : r;
    o_nack <= nack;
    o_done <= 1'b1;
    @(posedge i_clk);
    o_done <= 1'b0;
  endtask
endmodule // cmcp_host_model

`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the chassis manager
`timescale 1ns/10ps
`default_nettype none
`include "cmcp_regs.svh"

module tb_top import cmcp_pkg::*;;
  logic i_clk, i_nrst, clk10, slot_ref, rear_ref, slot_en, rear_en, ctrl, b;
  logic dut_oe, dut_dat, host_oe, scl, host_done, host_nack, o_ref_switch, o_sync100;
  wire logic sda;
  logic [7:0] host_rdata;
  logic [3:0] o_supply_enable;
  logic [1:0] strap;
  logic [95:0] rnd;
  cmcp_power_in_s pwr;
  cmcp_rails_s rails;
  cmcp_ref_e o_ref_select;
  logic [8:0] exp_q[$];
  cmcp_ref_e ref_q[$];
  int n_fail = 0;
  int n_checks = 0;

  // Open-drain data line with pull-up
  assign sda = ~(host_oe | (dut_oe & ~dut_dat));

  cmcp_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_smb_clk(scl), .i_smb_dat(sda), .o_smb_dat(dut_dat),
    .o_smb_dat_oe(dut_oe), .i_addr_strap(strap), .i_slot_ref_clk(slot_ref), .i_rear_reference_input(rear_ref),
    .i_clk10(clk10), .i_sync_ctrl(ctrl), .i_power(pwr), .i_rails(rails), .o_ref_select(o_ref_select),
    .o_ref_switch(o_ref_switch), .o_sync100(o_sync100), .o_supply_enable(o_supply_enable));

  cmcp_host_model u_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe), .o_done(host_done),
    .o_nack(host_nack), .o_rdata(host_rdata));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    clk10 <= ~clk10;
    slot_ref <= slot_ref ^ slot_en;
    rear_ref <= rear_ref ^ rear_en;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_ref(input cmcp_ref_e e, input cmcp_ref_e g);
    chk({14'h0000, e}, {14'h0000, g});
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    u_host.xfer(`CMCP_ADDR_DEFAULT, cmd, 8'h00, 1'b1);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    exp_q.push_back(9'h000);
    u_host.xfer(`CMCP_ADDR_DEFAULT, cmd, d, 1'b0);
  endtask

  task automatic sync_cnt(input logic [7:0] div, input logic ctl, input int e);
    int n;
    n = 0;
    wr(`CMCP_REG_SYNC_DIV, div);
    ctrl <= ctl;
    rd(`CMCP_REG_SYNC_DIV, div);
    for (int t = 0; t < 600 && e != 0 && o_sync100 !== 1'b1; t++) @(posedge i_clk);
    repeat (96) begin
      @(posedge i_clk);
      n += (o_sync100 === 1'b1);
    end
    chk(16'(e), 16'(n));
  endtask

  task automatic wait_q;
    for (int t = 0; t < 400 && ref_q.size() != 0; t++) @(posedge i_clk);
    if (ref_q.size() != 0) begin
      n_fail++;
      finish_test();
    end
  endtask

  // Result watcher
  always @(posedge i_clk) begin
    if (host_done === 1'b1) chk(16'(exp_q.size() ? exp_q.pop_front() : 9'h1ff), {7'h00, host_nack, host_rdata});
    if (o_ref_switch === 1'b1) chk_ref(ref_q.size() ? ref_q.pop_front() : cmcp_ref_e'(2'b11), o_ref_select);
  end

  initial begin
    #2000000;
    n_fail++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_nrst, clk10, slot_ref, rear_ref, slot_en, rear_en, ctrl, b} = 8'h00;
    pwr = 3'b000;
    strap = 2'b00;
    rails = '0;
    void'($urandom(8359));
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (8) @(posedge i_clk);
    rnd = {$urandom(), $urandom(), $urandom()};
    rails <= rnd[79:0];
    @(posedge i_clk);
    for (int i = 0; i < 10; i++) rd(8'(i), rails[79 - 8 * i -: 8]);
    wr(8'h00, ~rails[79:72]);
    rd(8'h00, rails[79:72]);
    rd(8'h0a, 8'h00);
    rd(`CMCP_REG_SYNC_DIV, `CMCP_SYNC_DIV_RST);
    exp_q.push_back(9'h100);
    u_host.xfer(`CMCP_ADDR_ALT_A, 8'h00, 8'h00, 1'b1);
    $display("register map test done");
    repeat (4) begin
      pwr <= 3'($urandom());
      repeat (8) @(posedge i_clk);
      b = pwr.power_source_selector ? pwr.slot_power_request_in : pwr.external_power_request_in;
      chk({12'h000, {4{b}}}, {12'h000, o_supply_enable});
      rd(8'h0e, {7'h00, pwr.power_source_selector});
      rd(8'h0f, {7'h00, pwr.slot_power_request_in});
      rd(8'h10, {7'h00, pwr.external_power_request_in});
      for (int i = 0; i < 4; i++) rd(8'h11 + 8'(i), {7'h00, b});
    end
    $display("power test done");
    sync_cnt(8'h02, 1'b0, 24);
    sync_cnt(8'h04, 1'b1, 12);
    sync_cnt(8'h00, 1'b0, 0);
    sync_cnt(8'h00, 1'b1, 48);
    sync_cnt(8'h01, 1'b0, 48);
    $display("sync test done");
    ref_q.push_back(CMCP_REF_SLOT);
    slot_en <= 1'b1;
    wait_q();
    rear_en <= 1'b1;
    repeat (150) @(posedge i_clk);
    ref_q.push_back(CMCP_REF_REAR);
    slot_en <= 1'b0;
    wait_q();
    ref_q.push_back(CMCP_REF_INT);
    rear_en <= 1'b0;
    wait_q();
    repeat (4) @(posedge i_clk);
    $display("reference test done");
    strap <= 2'b01;
    i_nrst <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (8) @(posedge i_clk);
    exp_q.push_back(9'h100);
    u_host.xfer(`CMCP_ADDR_DEFAULT, 8'h00, 8'h00, 1'b1);
    exp_q.push_back({1'b0, rails[79:72]});
    u_host.xfer(`CMCP_ADDR_ALT_A, 8'h00, 8'h00, 1'b1);
    repeat (4) @(posedge i_clk);
    $display("address strap test done");
    finish_test();
  end
endmodule // tb_top

`default_nettype wire
